// [src/sgw_wakeup_ctrl.sv]
// The AXI4-Lite slave port was decided locally.
`timescale 1ns/1ps
module sgw_wakeup_ctrl #(
   parameter int LOW_SPEED_DIV = sgw_pkg::LOW_SPEED_DIV
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [sgw_pkg::ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [sgw_pkg::DATA_W-1:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [sgw_pkg::ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [sgw_pkg::DATA_W-1:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic wait_exec,
   input wire logic [sgw_pkg::PINS_PORT_B-1:0] port_b_pins,
   input wire logic [sgw_pkg::PINS_PORT_C-1:0] port_c_pins,
   input wire logic [sgw_pkg::PINS_PORT_D-1:0] port_d_pins,
   output logic standby_power_down_q,
   output logic io_hold_q,
   output logic wake_q,
   output logic irq_q
);
   localparam int PORT_PINS [sgw_pkg::NUM_PORTS] = '{
      sgw_pkg::PINS_PORT_B, sgw_pkg::PINS_PORT_C, sgw_pkg::PINS_PORT_D};

   sgw_pkg::sgw_state_t state_q;
   sgw_pkg::sgw_port_ctrl_t port_ctrl_q [sgw_pkg::NUM_PORTS];
   logic [sgw_pkg::MODE_SELECT_W-1:0] power_down_mode_select_q;
   logic [sgw_pkg::INTERVAL_W-1:0] debounce_sample_interval_q;
   logic [sgw_pkg::NUM_PORTS-1:0] wake_flag_q;
   logic [sgw_pkg::NUM_PORTS-1:0] int_status_q;
   logic [sgw_pkg::NUM_PORTS-1:0] int_mask_q;
   logic [sgw_pkg::NUM_PORTS-1:0] port_wake;
   logic [15:0] port_pins [sgw_pkg::NUM_PORTS];
   logic sample_tick;

   logic [sgw_pkg::ADDR_W-1:0] aw_addr_q;
   logic [sgw_pkg::DATA_W-1:0] w_data_q;
   logic [3:0] w_strb_q;
   logic aw_have_q;
   logic w_have_q;
   logic aw_take;
   logic w_take;
   logic ar_take;
   logic do_write;
   logic [sgw_pkg::DATA_W-1:0] wmask;
   logic [sgw_pkg::DATA_W-1:0] old_word;
   logic [sgw_pkg::DATA_W-1:0] new_word;
   logic [sgw_pkg::DATA_W-1:0] rd_word;
   logic rd_hit;
   logic wr_hit;
   logic enter_standby;
   logic any_wake;
   logic release_req;
   logic status_read;

   // ==========================================================
   // port pins padded to a common width
   // ==========================================================
   assign port_pins[sgw_pkg::PORT_B] = port_b_pins;
   assign port_pins[sgw_pkg::PORT_C] = {2'h0, port_c_pins};
   assign port_pins[sgw_pkg::PORT_D] = {1'h0, port_d_pins};

   sgw_sample_tick #(
      .LOW_SPEED_DIV(LOW_SPEED_DIV)
   ) u_tick (
      .aclk(aclk),
      .aresetn(aresetn),
      .debounce_sample_interval(debounce_sample_interval_q),
      .sample_tick_q(sample_tick)
   );

   // ==========================================================
   // per-port wake detection
   // ==========================================================
   for (genvar p = 0; p < sgw_pkg::NUM_PORTS; p++)
   begin : g_port
      sgw_port_wake #(
         .NUM_PINS(PORT_PINS[p])
      ) u_port (
         .aclk(aclk),
         .aresetn(aresetn),
         .pins(port_pins[p]),
         .ctrl(port_ctrl_q[p]),
         .sample_tick(sample_tick),
         .standby(standby_power_down_q),
         .wake_q(port_wake[p])
      );
   end

   // ==========================================================
   // AXI4-Lite write channel
   // ==========================================================
   assign aw_take = s_axi_awvalid & s_axi_awready;
   assign w_take = s_axi_wvalid & s_axi_wready;
   assign do_write = aw_have_q & w_have_q & ~s_axi_bvalid;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_have_q <= 1'b0;
         w_have_q <= 1'b0;
         aw_addr_q <= '0;
         w_data_q <= '0;
         w_strb_q <= '0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= sgw_pkg::RESP_OKAY;
      end
      else
      begin
         if (aw_take)
         begin
            aw_have_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
         end
         else if (do_write)
            aw_have_q <= 1'b0;
         if (w_take)
         begin
            w_have_q <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
         end
         else if (do_write)
            w_have_q <= 1'b0;
         s_axi_awready <= ~(aw_take | (aw_have_q & ~do_write));
         s_axi_wready <= ~(w_take | (w_have_q & ~do_write));
         if (do_write)
         begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? sgw_pkg::RESP_OKAY : sgw_pkg::RESP_SLVERR;
         end
         else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end

   // ==========================================================
   // register read-back, shared by reads and masked writes
   // ==========================================================
   function automatic logic [31:0] ctrl_word(input sgw_pkg::sgw_port_ctrl_t c);
      logic [31:0] w;
      w = sgw_pkg::RESET_WORD;
      w[sgw_pkg::POS_PORT_WAKE_ENABLE] = c.port_wake_enable;
      w[sgw_pkg::POS_RISING_EDGE] = c.rising_edge_wake_enable;
      w[sgw_pkg::POS_FALLING_EDGE] = c.falling_edge_wake_enable;
      w[sgw_pkg::POS_PIN_SELECT_LSB +: 4] = c.wake_pin_select;
      w[sgw_pkg::POS_DEBOUNCE_ENABLE] = c.debounce_enable;
      return w;
   endfunction : ctrl_word

   function automatic sgw_pkg::sgw_port_ctrl_t word_ctrl(input logic [31:0] w);
      sgw_pkg::sgw_port_ctrl_t c;
      c.port_wake_enable = w[sgw_pkg::POS_PORT_WAKE_ENABLE];
      c.rising_edge_wake_enable = w[sgw_pkg::POS_RISING_EDGE];
      c.falling_edge_wake_enable = w[sgw_pkg::POS_FALLING_EDGE];
      c.wake_pin_select = w[sgw_pkg::POS_PIN_SELECT_LSB +: 4];
      c.debounce_enable = w[sgw_pkg::POS_DEBOUNCE_ENABLE];
      return c;
   endfunction : word_ctrl

   function automatic logic [32:0] reg_read(input logic [7:0] a,
      input logic [31:0] b, input logic [31:0] c, input logic [31:0] d,
      input logic [2:0] mode, input logic [3:0] ivl, input logic [2:0] flg,
      input logic [2:0] sts, input logic [2:0] msk);
      logic [31:0] w;
      logic hit;
      w = sgw_pkg::RESET_WORD;
      hit = 1'b1;
      if (a[7:2] == sgw_pkg::OFF_PORT_B_CTRL[7:2])
         w = b;
      else if (a[7:2] == sgw_pkg::OFF_PORT_C_CTRL[7:2])
         w = c;
      else if (a[7:2] == sgw_pkg::OFF_PORT_D_CTRL[7:2])
         w = d;
      else if (a[7:2] == sgw_pkg::OFF_HOLD_RELEASE[7:2])
         w = sgw_pkg::RESET_WORD;
      else if (a[7:2] == sgw_pkg::OFF_MODE_SELECT[7:2])
         w[2:0] = mode;
      else if (a[7:2] == sgw_pkg::OFF_DB_INTERVAL[7:2])
         w[3:0] = ivl;
      else if (a[7:2] == sgw_pkg::OFF_WAKE_FLAGS[7:2])
         w[2:0] = flg;
      else if (a[7:2] == sgw_pkg::OFF_INT_STATUS[7:2])
         w[2:0] = sts;
      else if (a[7:2] == sgw_pkg::OFF_INT_MASK[7:2])
         w[2:0] = msk;
      else
         hit = 1'b0;
      return {hit, w};
   endfunction : reg_read

   assign {wr_hit, old_word} = reg_read(aw_addr_q, ctrl_word(port_ctrl_q[0]),
      ctrl_word(port_ctrl_q[1]), ctrl_word(port_ctrl_q[2]),
      power_down_mode_select_q, debounce_sample_interval_q, wake_flag_q,
      int_status_q, int_mask_q);
   assign {rd_hit, rd_word} = reg_read(s_axi_araddr, ctrl_word(port_ctrl_q[0]),
      ctrl_word(port_ctrl_q[1]), ctrl_word(port_ctrl_q[2]),
      power_down_mode_select_q, debounce_sample_interval_q, wake_flag_q,
      int_status_q, int_mask_q);
   assign wmask = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}}, {8{w_strb_q[1]}}, {8{w_strb_q[0]}}};
   assign new_word = (old_word & ~wmask) | (w_data_q & wmask);

   // ==========================================================
   // software registers
   // ==========================================================
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         for (int p = 0; p < sgw_pkg::NUM_PORTS; p++)
            port_ctrl_q[p] <= '0;
         power_down_mode_select_q <= '0;
         debounce_sample_interval_q <= '0;
         int_mask_q <= '0;
      end
      else if (do_write)
      begin
         if (aw_addr_q[7:2] == sgw_pkg::OFF_PORT_B_CTRL[7:2])
            port_ctrl_q[sgw_pkg::PORT_B] <= word_ctrl(new_word);
         else if (aw_addr_q[7:2] == sgw_pkg::OFF_PORT_C_CTRL[7:2])
            port_ctrl_q[sgw_pkg::PORT_C] <= word_ctrl(new_word);
         else if (aw_addr_q[7:2] == sgw_pkg::OFF_PORT_D_CTRL[7:2])
            port_ctrl_q[sgw_pkg::PORT_D] <= word_ctrl(new_word);
         else if (aw_addr_q[7:2] == sgw_pkg::OFF_MODE_SELECT[7:2])
            power_down_mode_select_q <= new_word[2:0];
         else if (aw_addr_q[7:2] == sgw_pkg::OFF_DB_INTERVAL[7:2])
            debounce_sample_interval_q <= new_word[3:0];
         else if (aw_addr_q[7:2] == sgw_pkg::OFF_INT_MASK[7:2])
            int_mask_q <= new_word[2:0];
      end
   end

   // release is a one-shot write strobe; nothing is stored, so it reads zero
   assign release_req = do_write & w_strb_q[0]
      & (aw_addr_q[7:2] == sgw_pkg::OFF_HOLD_RELEASE[7:2])
      & w_data_q[sgw_pkg::POS_IO_HOLD_RELEASE];

   // ==========================================================
   // AXI4-Lite read channel
   // ==========================================================
   assign ar_take = s_axi_arvalid & s_axi_arready;
   assign status_read = ar_take & (s_axi_araddr[7:2] == sgw_pkg::OFF_INT_STATUS[7:2]);

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= sgw_pkg::RESP_OKAY;
      end
      else
      begin
         s_axi_arready <= ~(ar_take | (s_axi_rvalid & ~s_axi_rready));
         if (ar_take)
         begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= rd_hit ? sgw_pkg::RESP_OKAY : sgw_pkg::RESP_SLVERR;
         end
         else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
   end

   // ==========================================================
   // standby sequencing
   // ==========================================================
   assign enter_standby = (state_q == sgw_pkg::ST_RUN) & wait_exec
      & (power_down_mode_select_q == sgw_pkg::MODE_STANDBY_POWER_DOWN);
   assign any_wake = (state_q == sgw_pkg::ST_STANDBY) & (|port_wake);

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         state_q <= sgw_pkg::ST_RUN;
         standby_power_down_q <= 1'b0;
         wake_q <= 1'b0;
      end
      else
      begin
         wake_q <= any_wake;
         case (state_q)
            sgw_pkg::ST_RUN:
            begin
               if (enter_standby)
               begin
                  state_q <= sgw_pkg::ST_STANDBY;
                  standby_power_down_q <= 1'b1;
               end
            end
            sgw_pkg::ST_STANDBY:
            begin
               if (any_wake)
               begin
                  state_q <= sgw_pkg::ST_RUN;
                  standby_power_down_q <= 1'b0;
               end
            end
            default:
            begin
               state_q <= sgw_pkg::ST_RUN;
               standby_power_down_q <= 1'b0;
            end
         endcase
      end
   end

   // hold outlives the wake; a release during standby is ignored
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         io_hold_q <= 1'b0;
      else if (enter_standby)
         io_hold_q <= 1'b1;
      else if (release_req & (state_q == sgw_pkg::ST_RUN))
         io_hold_q <= 1'b0;
   end

   // ==========================================================
   // wake flags and interrupt
   // ==========================================================
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         wake_flag_q <= '0;
      else if (enter_standby)
         wake_flag_q <= '0;
      else if (any_wake)
         wake_flag_q <= wake_flag_q | port_wake;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         int_status_q <= '0;
         irq_q <= 1'b0;
      end
      else
      begin
         // a wake in the cycle of the clearing read survives it
         int_status_q <= (int_status_q & ~{sgw_pkg::NUM_PORTS{status_read}})
            | (port_wake & {sgw_pkg::NUM_PORTS{any_wake}});
         irq_q <= |(int_status_q & int_mask_q);
      end
   end

endmodule : sgw_wakeup_ctrl

// [src/sgw_pkg.sv]
package sgw_pkg;

   // ==========================================================
   // bus and register map
   // ==========================================================
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam logic [7:0] OFF_MODE_SELECT = 8'h90;
   localparam logic [7:0] OFF_WAKE_FLAGS = 8'h94;
   localparam logic [7:0] OFF_DB_INTERVAL = 8'h9C;
   localparam logic [7:0] OFF_PORT_B_CTRL = 8'hA4;
   localparam logic [7:0] OFF_PORT_C_CTRL = 8'hA8;
   localparam logic [7:0] OFF_PORT_D_CTRL = 8'hAC;
   localparam logic [7:0] OFF_HOLD_RELEASE = 8'hB0;
   localparam logic [7:0] OFF_INT_STATUS = 8'hB8;
   localparam logic [7:0] OFF_INT_MASK = 8'hBC;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ==========================================================
   // field positions and reset values
   // ==========================================================
   localparam int POS_PORT_WAKE_ENABLE = 0;
   localparam int POS_RISING_EDGE = 1;
   localparam int POS_FALLING_EDGE = 2;
   localparam int POS_PIN_SELECT_LSB = 4;
   localparam int POS_DEBOUNCE_ENABLE = 8;
   localparam int POS_IO_HOLD_RELEASE = 0;
   localparam int MODE_SELECT_W = 3;
   localparam int INTERVAL_W = 4;
   localparam logic [2:0] MODE_STANDBY_POWER_DOWN = 3'h4;
   localparam logic [31:0] RESET_WORD = 32'h00000000;
   localparam int NUM_PORTS = 3;
   localparam int PORT_B = 0;
   localparam int PORT_C = 1;
   localparam int PORT_D = 2;
   localparam int PINS_PORT_B = 16;
   localparam int PINS_PORT_C = 14;
   localparam int PINS_PORT_D = 15;

   // ==========================================================
   // timing
   // ==========================================================
   localparam int CLK_FREQ_HZ = 25000000;
   localparam int LOW_SPEED_RC_OSC_HZ = 10000;
   localparam int LOW_SPEED_DIV = CLK_FREQ_HZ / LOW_SPEED_RC_OSC_HZ;
   localparam int INTERVAL_CNT_W = 16;

   // ==========================================================
   // types
   // ==========================================================
   typedef struct packed {
      logic debounce_enable;
      logic [3:0] wake_pin_select;
      logic falling_edge_wake_enable;
      logic rising_edge_wake_enable;
      logic port_wake_enable;
   } sgw_port_ctrl_t;

   typedef enum logic {
      ST_RUN,
      ST_STANDBY
   } sgw_state_t;

endpackage : sgw_pkg

// [src/sgw_sample_tick.sv]
`timescale 1ns/1ps
module sgw_sample_tick #(
   parameter int LOW_SPEED_DIV = sgw_pkg::LOW_SPEED_DIV
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [sgw_pkg::INTERVAL_W-1:0] debounce_sample_interval,
   output logic sample_tick_q
);
   localparam int DIV_W = $clog2(LOW_SPEED_DIV + 1);
   localparam logic [DIV_W-1:0] DIV_END = DIV_W'(LOW_SPEED_DIV - 1);

   logic [DIV_W-1:0] div_q;
   logic [sgw_pkg::INTERVAL_CNT_W-1:0] interval_q;
   logic [sgw_pkg::INTERVAL_CNT_W-1:0] interval_end;
   logic osc_tick;

   // ==========================================================
   // low-speed oscillator emulated as a tick of the bus clock
   // ==========================================================
   assign osc_tick = (div_q == DIV_END);

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         div_q <= '0;
      else if (osc_tick)
         div_q <= '0;
      else
         div_q <= DIV_W'(div_q + 1'b1);
   end

   // ==========================================================
   // sampling interval: 2**code oscillator clocks
   // ==========================================================
   assign interval_end = sgw_pkg::INTERVAL_CNT_W'(
      (17'h00001 << debounce_sample_interval) - 17'h00001);

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         interval_q <= '0;
         sample_tick_q <= 1'b0;
      end
      else
      begin
         sample_tick_q <= 1'b0;
         if (osc_tick)
         begin
            if (interval_q >= interval_end)
            begin
               interval_q <= '0;
               sample_tick_q <= 1'b1;
            end
            else
               interval_q <= sgw_pkg::INTERVAL_CNT_W'(interval_q + 1'b1);
         end
      end
   end

endmodule : sgw_sample_tick

// [src/sgw_port_wake.sv]
`timescale 1ns/1ps
module sgw_port_wake #(
   parameter int NUM_PINS = 16
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [15:0] pins,
   input sgw_pkg::sgw_port_ctrl_t ctrl,
   input wire logic sample_tick,
   input wire logic standby,
   output logic wake_q
);
   logic pin_valid;
   logic pin_lvl;
   logic raw_prev_q;
   logic samp_a_q;
   logic samp_b_q;
   logic stable_q;
   logic filt_lvl;
   logic cur_lvl;
   logic prev_lvl;
   logic rise;
   logic fall;

   // ==========================================================
   // pin selection; reserved codes select no pin
   // ==========================================================
   assign pin_valid = ({1'b0, ctrl.wake_pin_select} < 5'(NUM_PINS));
   assign pin_lvl = pins[ctrl.wake_pin_select] & pin_valid;

   // ==========================================================
   // de-bounce: a new level must be seen on two successive samples
   // ==========================================================
   assign filt_lvl = (samp_a_q == samp_b_q) ? samp_a_q : stable_q;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         raw_prev_q <= 1'b0;
         samp_a_q <= 1'b0;
         samp_b_q <= 1'b0;
         stable_q <= 1'b0;
      end
      else
      begin
         raw_prev_q <= pin_lvl;
         stable_q <= filt_lvl;
         if (sample_tick)
         begin
            samp_a_q <= pin_lvl;
            samp_b_q <= samp_a_q;
         end
      end
   end

   // filter sits only in the edge path, the sole detection style here
   assign cur_lvl = ctrl.debounce_enable ? filt_lvl : pin_lvl;
   assign prev_lvl = ctrl.debounce_enable ? stable_q : raw_prev_q;
   assign rise = cur_lvl & ~prev_lvl;
   assign fall = ~cur_lvl & prev_lvl;

   // ==========================================================
   // wake request
   // ==========================================================
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         wake_q <= 1'b0;
      else
         wake_q <= standby & ctrl.port_wake_enable & pin_valid
            & ((rise & ctrl.rising_edge_wake_enable)
            | (fall & ctrl.falling_edge_wake_enable));
   end

endmodule : sgw_port_wake

// [bench/sgw_props.sv]
`timescale 1ns/1ps
module sgw_props #(
   parameter int LOW_SPEED_DIV = 4
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic wait_exec,
   input wire logic standby_power_down_q,
   input wire logic io_hold_q,
   input wire logic wake_q
);
   // ==========================================================
   // handshake history
   // ==========================================================
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // write takes delayed by two edges, to tie a hold drop to its write
   logic [1:0] wt_q;
   always_ff @(posedge aclk)
   begin
      wt_q <= {wt_q[0], s_axi_wvalid & s_axi_wready};
   end
   sequence s_wr_take;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence s_rd_take;
      s_axi_arvalid && s_axi_arready;
   endsequence
   // ==========================================================
   // properties
   // ==========================================================
   a_write_resp_time: assert property (s_wr_take |-> ##2 s_axi_bvalid)
      else $error("write response late");
   a_read_resp_time: assert property (s_rd_take |=> s_axi_rvalid)
      else $error("read data late");
   a_read_refuse: assert property (s_rd_take |=> !s_axi_arready)
      else $error("second read accepted");
   a_rvalid_drop: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
      else $error("read data repeated");
   a_wake_pulse_exit: assert property (
      wake_q |-> $fell(standby_power_down_q) ##1 !wake_q)
      else $error("wake pulse outside standby exit");
   a_hold_in_standby: assert property (standby_power_down_q |-> io_hold_q)
      else $error("io not held in standby");
   a_standby_entry: assert property ($rose(standby_power_down_q) |-> $past(wait_exec))
      else $error("standby without wait");
   a_hold_release: assert property (
      $fell(io_hold_q) |-> wt_q[1] && !standby_power_down_q)
      else $error("hold dropped without release write");
endmodule : sgw_props

bind sgw_wakeup_ctrl sgw_props #(.LOW_SPEED_DIV(LOW_SPEED_DIV)) u_props (.aclk, .aresetn,
   .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
   .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .wait_exec,
   .standby_power_down_q, .io_hold_q, .wake_q);

// [bench/sgw_pins_model.sv]
`timescale 1ns/1ps
module sgw_pins_model (
   input wire logic aclk,
   output logic wait_exec,
   output logic [15:0] port_b_pins,
   output logic [13:0] port_c_pins,
   output logic [14:0] port_d_pins
);
   initial
   begin
      wait_exec = 1'b0;
      port_b_pins = 16'h0000;
      port_c_pins = 14'h0000;
      port_d_pins = 15'h0000;
   end
   // wait instruction lasts one clock; only mode code 100 turns it into standby
   task automatic sleep();
      wait_exec <= 1'b1;
      @(posedge aclk);
      wait_exec <= 1'b0;
   endtask : sleep
   task automatic set(input logic [15:0] b, input logic [13:0] c, input logic [14:0] d);
      port_b_pins <= b;
      port_c_pins <= c;
      port_d_pins <= d;
      @(posedge aclk);
   endtask : set
endmodule : sgw_pins_model

// [bench/test_standby_gpio_wakeup_ctrl.sv]
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_errors++; \
   $display("mismatch t=%0t got=%h exp=%h", $time, a, b); end end
module test_standby_gpio_wakeup_ctrl;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rv;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
   logic s_axi_bready = 1'b1, s_axi_rready = 1'b1;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, rr;
   logic standby_power_down_q, io_hold_q, wake_q, irq_q, wait_exec;
   logic [15:0] port_b_pins;
   logic [13:0] port_c_pins;
   logic [14:0] port_d_pins;
   logic [7:0] offs [4] = '{8'hA4, 8'hA8, 8'hAC, 8'hB0};
   int n_errors = 0, cmp_count = 0;
   bit seen;
   always #20 aclk = ~aclk;
   // short oscillator divide keeps de-bounce runs to tens of cycles
   sgw_wakeup_ctrl #(.LOW_SPEED_DIV(4)) dut (.*);
   sgw_pins_model pm (.aclk, .wait_exec, .port_b_pins, .port_c_pins, .port_d_pins);
   // ==========================================================
   // bus tasks
   // ==========================================================
   task test_done;
      $display("errors=%0d compares=%0d", n_errors, cmp_count);
      if (n_errors == 0 && cmp_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : test_done
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      int i;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      i = 0;
      do
      begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         i++;
      end while (s_axi_bvalid !== 1'b1 && i < 50);
      r = s_axi_bresp;
      if (i >= 50)
      begin
         n_errors++;
         test_done();
      end
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      int i;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      i = 0;
      do
      begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         i++;
      end while (s_axi_rvalid !== 1'b1 && i < 50);
      d = s_axi_rdata;
      r = s_axi_rresp;
      if (i >= 50)
      begin
         n_errors++;
         test_done();
      end
   endtask : rd
   task automatic rchk(input logic [7:0] a, input logic [31:0] e);
      rd(a, rv, rr);
      `CHK(rv, e)
   endtask : rchk
   task automatic watch(input int n, input bit e);
      seen = 1'b0;
      repeat (n)
      begin
         @(posedge aclk);
         if (wake_q === 1'b1) seen = 1'b1;
      end
      `CHK(seen, e)
   endtask : watch
   // ==========================================================
   // sequence
   // ==========================================================
   initial
   begin
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      foreach (offs[k]) rchk(offs[k], 32'h0);
      foreach (offs[k])
      begin
         wr(offs[k], 32'hFFFFFFFF, rr);
         rchk(offs[k], k == 3 ? 32'h0 : 32'h1F7);
      end
      wr(8'h00, 32'h1, rr);
      `CHK(rr, 2'h2)
      rchk(8'h00, 32'h0);
      `CHK(rr, 2'h2)
      wr(8'h90, 32'h4, rr);
      wr(8'hBC, 32'h7, rr);
      wr(8'hA4, 32'h53, rr);
      wr(8'hA8, 32'hE7, rr);
      wr(8'hAC, 32'hE6, rr);
      pm.set(16'h0020, 14'h0000, 15'h0000);
      pm.sleep();
      @(posedge aclk);
      `CHK(standby_power_down_q, 1'b1)
      `CHK(io_hold_q, 1'b1)
      pm.set(16'h0000, 14'h3FFF, 15'h4000);
      watch(10, 1'b0);
      pm.set(16'h0020, 14'h3FFF, 15'h4000);
      watch(10, 1'b1);
      rchk(8'h94, 32'h1);
      `CHK(irq_q, 1'b1)
      rchk(8'hB8, 32'h1);
      rchk(8'hB8, 32'h0);
      `CHK(irq_q, 1'b0)
      `CHK(io_hold_q, 1'b1)
      wr(8'hB0, 32'h1, rr);
      `CHK(io_hold_q, 1'b0)
      wr(8'hAC, 32'hE5, rr);
      wr(8'hBC, 32'h3, rr);
      pm.sleep();
      rchk(8'h94, 32'h0);
      pm.set(16'h0020, 14'h3FFF, 15'h0000);
      watch(10, 1'b1);
      `CHK(irq_q, 1'b0)
      rchk(8'hB8, 32'h4);
      rchk(8'h94, 32'h4);
      wr(8'h9C, 32'h0, rr);
      wr(8'hA4, 32'h153, rr);
      pm.set(16'h0000, 14'h3FFF, 15'h0000);
      repeat (40) @(posedge aclk);
      pm.sleep();
      // a pulse as long as one sample period meets exactly one sample
      pm.set(16'h0020, 14'h3FFF, 15'h0000);
      repeat (3) @(posedge aclk);
      pm.set(16'h0000, 14'h3FFF, 15'h0000);
      watch(30, 1'b0);
      wr(8'h9C, 32'h1, rr);
      `CHK(rr, 2'h0)
      pm.set(16'h0020, 14'h3FFF, 15'h0000);
      repeat (7) @(posedge aclk);
      pm.set(16'h0000, 14'h3FFF, 15'h0000);
      watch(30, 1'b0);
      pm.set(16'h0020, 14'h3FFF, 15'h0000);
      watch(40, 1'b1);
      test_done();
   end
endmodule : test_standby_gpio_wakeup_ctrl
